// ### rtl/spsel_map.svh
// Purpose: named constants for the chip-select manager
// Assumes: 100 MHz master clock
// Notes:   definitions only
`ifndef SPSEL_MAP_SVH
`define SPSEL_MAP_SVH
`define SPS_CLK_NS       10
`define SPS_SCK_HALF_NS  40
`define SPS_SCK_HALF_CYC ((`SPS_SCK_HALF_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)
`define SPS_DIV_LAST     4'(`SPS_SCK_HALF_CYC - 1)
`define SPS_CS_IDLE      4'hf
`define SPS_BITS_BASE    5'h08
`define SPS_BITS_MAX     5'h10
`define SPS_BITS_SPAN    4'h8
`define SPS_DLY_MIN      8'h01
`endif

// ### rtl/spsel_pkg.sv
// Purpose: shared types for the chip-select manager
// Assumes: nothing
// Notes:   transmit word layout matches the 32-bit buffer entry
package spsel_pkg;
  typedef struct packed {
    logic [6:0]  spare_hi;
    logic        last;
    logic [3:0]  spare;
    logic [3:0]  cs;
    logic [15:0] data;
  } spsel_txw_t;

  typedef struct packed {
    logic       keep;
    logic       force_rel;
    logic [3:0] bits;
  } spsel_cscfg_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DLY   = 3'b010,
    ST_SHIFT = 3'b100
  } spsel_st_t;
endpackage

// ### rtl/spsel_top.sv
// Purpose: chip-select management and word shifting for an spi master
// Assumes: master mode only; serial mode 0; one word holding register
// Notes:   inter-select delay is a count of master clocks, at least one
//
// Summary of operation
// - without keep-active, all four select lines idle high outside transfers.
// - fixed mode takes the select from the mode field, ignores word field.
// - variable mode takes the select from each transmit word.
// - word holds data low, 4-bit select, 4 spare, last flag, 7 spare.
// - only the configured 8 to 16 bits of each word are shifted.
// - decode mode drives the four lines with the raw select code.
// - without decode only the lowest-numbered low bit is asserted.
// - all ones shown when idle, so that code addresses nobody.
// - decode mode maps each group of four codes to one config.
// - transmit-empty sets when the holding word moves to the shifter.
// - reload in time to the same select keeps it asserted.
// - keep-active holds the select until another select is needed.
// - last-transfer command releases the select after the next word.
// - force-release without keep-active releases between every word.
// - disable after transmit-complete also releases, keeping configuration.
// - master detects a mode fault when line 0 is pulled low externally.
// - mode fault sets a sticky flag and disables until re-enabled.
// - fault detection active while enabled, off with the disable bit.
// - disable completes the transfer in progress, then floats all pins.
`include "spsel_map.svh"
module spsel_top (
  // clock and reset
  input  wire logic                         MCLK,
  input  wire logic                         RST,
  // commands, one-cycle pulses
  input  wire logic                         ENABLE_CMD,
  input  wire logic                         DISABLE_CMD,
  input  wire logic                         LAST_XFER_CMD,
  // mode settings
  input  wire logic                         SELECT_MODE,
  input  wire logic                         DECODE_EN,
  input  wire logic                         MODE_FAULT_FLAG_DIS,
  input  wire logic [3:0]                   MR_CS_FIELD,
  input  wire logic [7:0]                   INTER_SEL_DLY,
  input  wire spsel_pkg::spsel_cscfg_t [3:0] CS_CFG,
  // transmit holding register
  input  wire logic                         TX_WR,
  input  wire spsel_pkg::spsel_txw_t        TX_WORD,
  // status
  input  wire logic                         STATUS_RD,
  input  wire logic                         RX_RD,
  output logic                              TX_EMPTY,
  output logic                              RX_FULL,
  output logic                              TX_DONE,
  output logic                              MODE_FAULT,
  output logic                              ENABLED,
  output logic [15:0]                       RX_DATA,
  // pins
  output logic [3:0]                        CS_N_O,
  output logic [3:0]                        CS_N_OE,
  input  wire logic                         CS0_I,
  output logic                              SCK_O,
  output logic                              SCK_OE,
  output logic                              MOSI_O,
  output logic                              MOSI_OE,
  input  wire logic                         MISO_I
);

  // lowest low bit, or the upper pair when decoding
  function automatic logic [1:0] cfg_idx(input logic [3:0] code, input logic dec);
    if (dec)          return code[3:2];
    else if (!code[0]) return 2'd0;
    else if (!code[1]) return 2'd1;
    else if (!code[2]) return 2'd2;
    else               return 2'd3;
  endfunction

  function automatic logic [3:0] cs_drive(input logic [3:0] code, input logic dec);
    if (dec || code == `SPS_CS_IDLE) return code;
    else return ~(4'h1 << cfg_idx(code, 1'b0));
  endfunction

  function automatic logic [4:0] bits_of(input spsel_pkg::spsel_cscfg_t c);
    if (c.bits >= `SPS_BITS_SPAN) return `SPS_BITS_MAX;
    else return `SPS_BITS_BASE + {1'b0, c.bits};
  endfunction

  spsel_pkg::spsel_st_t   state_r;
  spsel_pkg::spsel_txw_t  thr_r;
  logic                   thr_empty_r;
  logic [3:0]             cur_code_r;
  logic [3:0]             cur_drv_r;
  logic [1:0]             cur_idx_r;
  logic [4:0]             cur_bits_r;
  logic [4:0]             bit_cnt_r;
  logic [3:0]             div_cnt_r;
  logic [7:0]             dly_cnt_r;
  logic [15:0]            sh_r;
  logic [15:0]            rx_sh_r;
  logic                   last_r;
  logic                   last_pend_r;
  logic                   cs_act_r;
  logic [3:0]             cs_n_r;
  logic                   sck_r;
  logic                   en_r;
  logic                   dis_pend_r;
  logic                   fault_r;
  logic                   rx_full_r;
  logic [15:0]            rx_data_r;
  logic                   tx_done_r;
  logic                   cs0_s1_r;
  logic                   cs0_s2_r;
  logic                   miso_s1_r;
  logic                   miso_s2_r;
  logic                   own0_d1_r;
  logic                   own0_d2_r;

  logic [3:0]  nxt_code;
  logic [3:0]  nxt_drv;
  logic [1:0]  nxt_idx;
  logic [7:0]  dly_lim;
  logic        start_go;
  logic        tick;
  logic        word_end;
  logic        fault_det;
  logic        release_now;

  // fixed mode ignores the word's select field
  assign nxt_code  = SELECT_MODE ? thr_r.cs : MR_CS_FIELD;
  assign nxt_drv   = cs_drive(nxt_code, DECODE_EN);
  assign nxt_idx   = cfg_idx(nxt_code, DECODE_EN);
  assign dly_lim   = (INTER_SEL_DLY < `SPS_DLY_MIN) ? `SPS_DLY_MIN : INTER_SEL_DLY;
  assign start_go  = (state_r == spsel_pkg::ST_IDLE) && en_r && !thr_empty_r
                     && !dis_pend_r && !fault_det;
  assign tick      = (state_r == spsel_pkg::ST_SHIFT) && (div_cnt_r == `SPS_DIV_LAST);
  assign word_end  = tick && sck_r && (bit_cnt_r + 5'h01 == cur_bits_r);
  // only watch line 0 while it is ours and idle high; our own release
  // reaches the synced pin two clocks late, so wait that out as well
  assign fault_det = en_r && !MODE_FAULT_FLAG_DIS && cs_n_r[0] && own0_d1_r && own0_d2_r
                     && !cs0_s2_r;
  // keep-active outranks force-release; last and disable outrank both
  assign release_now = last_r || dis_pend_r || DISABLE_CMD ||
                       (!CS_CFG[cur_idx_r].keep && (CS_CFG[cur_idx_r].force_rel ||
                        thr_empty_r || nxt_drv != cur_drv_r));

  // pin synchronisers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cs0_s1_r  <= 1'b1;
      cs0_s2_r  <= 1'b1;
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
      own0_d1_r <= 1'b1;
      own0_d2_r <= 1'b1;
    end else begin
      cs0_s1_r  <= CS0_I;
      cs0_s2_r  <= cs0_s1_r;
      miso_s1_r <= MISO_I;
      miso_s2_r <= miso_s1_r;
      own0_d1_r <= cs_n_r[0];
      own0_d2_r <= own0_d1_r;
    end
  end

  // holding register; a write in the load cycle wins
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      thr_r       <= '0;
      thr_empty_r <= 1'b1;
    end else if (TX_WR) begin
      thr_r       <= TX_WORD;
      thr_empty_r <= 1'b0;
    end else if (start_go) begin
      thr_empty_r <= 1'b1;
    end
  end

  // last-transfer command waits for the next word
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) last_pend_r <= 1'b0;
    else if (LAST_XFER_CMD) last_pend_r <= 1'b1;
    else if (start_go) last_pend_r <= 1'b0;
  end

  // sequencer, select lines and shifter
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_r    <= spsel_pkg::ST_IDLE;
      cur_code_r <= `SPS_CS_IDLE;
      cur_drv_r  <= `SPS_CS_IDLE;
      cur_idx_r  <= '0;
      cur_bits_r <= `SPS_BITS_BASE;
      bit_cnt_r  <= '0;
      div_cnt_r  <= '0;
      dly_cnt_r  <= '0;
      sh_r       <= '0;
      rx_sh_r    <= '0;
      last_r     <= 1'b0;
      cs_act_r   <= 1'b0;
      cs_n_r     <= `SPS_CS_IDLE;
      sck_r      <= 1'b0;
    end else if (fault_det) begin
      // a fault aborts at once: the bus belongs to the other master
      state_r  <= spsel_pkg::ST_IDLE;
      cs_act_r <= 1'b0;
      cs_n_r   <= `SPS_CS_IDLE;
      sck_r    <= 1'b0;
    end else begin
      case (state_r)
        spsel_pkg::ST_IDLE: begin
          if (!en_r) begin
            cs_act_r <= 1'b0;
            cs_n_r   <= `SPS_CS_IDLE;
          end
          if (start_go) begin
            cur_code_r <= nxt_code;
            cur_drv_r  <= nxt_drv;
            cur_idx_r  <= nxt_idx;
            cur_bits_r <= bits_of(CS_CFG[nxt_idx]);
            sh_r       <= thr_r.data << (`SPS_BITS_MAX - bits_of(CS_CFG[nxt_idx]));
            rx_sh_r    <= '0;
            last_r     <= last_pend_r || (SELECT_MODE && thr_r.last);
            bit_cnt_r  <= '0;
            div_cnt_r  <= '0;
            dly_cnt_r  <= '0;
            if (cs_act_r && cs_n_r == nxt_drv) begin
              state_r <= spsel_pkg::ST_SHIFT;
            end else begin
              cs_act_r <= 1'b0;
              cs_n_r   <= `SPS_CS_IDLE;
              state_r  <= spsel_pkg::ST_DLY;
            end
          end
        end
        spsel_pkg::ST_DLY: begin
          dly_cnt_r <= dly_cnt_r + 8'h01;
          if (dly_cnt_r + 8'h01 >= dly_lim) begin
            cs_n_r   <= cur_drv_r;
            cs_act_r <= (cur_drv_r != `SPS_CS_IDLE);
            state_r  <= spsel_pkg::ST_SHIFT;
          end
        end
        spsel_pkg::ST_SHIFT: begin
          div_cnt_r <= tick ? '0 : div_cnt_r + 4'h1;
          if (tick && !sck_r) begin
            sck_r <= 1'b1;
          end else if (tick) begin
            sck_r     <= 1'b0;
            rx_sh_r   <= {rx_sh_r[14:0], miso_s2_r};
            sh_r      <= {sh_r[14:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 5'h01;
          end
          if (word_end) begin
            state_r <= spsel_pkg::ST_IDLE;
            if (release_now) begin
              cs_act_r <= 1'b0;
              cs_n_r   <= `SPS_CS_IDLE;
            end
          end
        end
        default: begin
          state_r <= spsel_pkg::ST_IDLE;
          cs_n_r  <= `SPS_CS_IDLE;
        end
      endcase
    end
  end

  // enable, deferred disable, sticky mode fault
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      en_r       <= 1'b0;
      dis_pend_r <= 1'b0;
      fault_r    <= 1'b0;
    end else begin
      if (fault_det) fault_r <= 1'b1;
      else if (STATUS_RD) fault_r <= 1'b0;
      if (fault_det) begin
        en_r       <= 1'b0;
        dis_pend_r <= 1'b0;
      end else if (DISABLE_CMD || dis_pend_r) begin
        // the word on the wire is finished first
        if (state_r == spsel_pkg::ST_IDLE && !start_go) begin
          en_r       <= 1'b0;
          dis_pend_r <= 1'b0;
        end else begin
          dis_pend_r <= 1'b1;
        end
      end else if (ENABLE_CMD) begin
        en_r <= 1'b1;
      end
    end
  end

  // receive data and completion
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rx_data_r <= '0;
      rx_full_r <= 1'b0;
      tx_done_r <= 1'b1;
    end else begin
      if (word_end) rx_data_r <= {rx_sh_r[14:0], miso_s2_r};
      if (word_end) rx_full_r <= 1'b1;
      else if (RX_RD) rx_full_r <= 1'b0;
      tx_done_r <= (state_r == spsel_pkg::ST_IDLE) && thr_empty_r && !start_go;
    end
  end

  assign TX_EMPTY   = thr_empty_r;
  assign RX_FULL    = rx_full_r;
  assign RX_DATA    = rx_data_r;
  assign TX_DONE    = tx_done_r;
  assign MODE_FAULT = fault_r;
  assign ENABLED    = en_r;
  assign CS_N_O     = cs_n_r;
  assign CS_N_OE    = {4{en_r}};
  assign SCK_O      = sck_r;
  assign SCK_OE     = en_r;
  assign MOSI_O     = sh_r[15];
  assign MOSI_OE    = en_r;

  // helper: serial clock rises counted per word
  logic [4:0] rise_cnt_r;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) rise_cnt_r <= '0;
    else if (state_r != spsel_pkg::ST_SHIFT) rise_cnt_r <= '0;
    else if (tick && !sck_r) rise_cnt_r <= rise_cnt_r + 5'h01;
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_word_end;
    word_end && !fault_det;
  endsequence
  sequence s_released;
    CS_N_O == `SPS_CS_IDLE;
  endsequence

  property p_idle_high;
    (state_r == spsel_pkg::ST_IDLE && !cs_act_r) |-> s_released;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("select low while idle");

  property p_fixed_src;
    (start_go && !SELECT_MODE) |=> cur_code_r == $past(MR_CS_FIELD);
  endproperty
  a_fixed_src: assert property (p_fixed_src) else $error("fixed select not taken");

  property p_var_src;
    (start_go && SELECT_MODE) |=> cur_code_r == $past(thr_r.cs);
  endproperty
  a_var_src: assert property (p_var_src) else $error("word select not taken");

  property p_bits;
    s_word_end |-> rise_cnt_r == cur_bits_r;
  endproperty
  a_bits: assert property (p_bits) else $error("wrong bit count shifted");

  property p_decode;
    (state_r == spsel_pkg::ST_SHIFT && DECODE_EN && $stable(DECODE_EN))
      |-> CS_N_O == cur_code_r || !cs_act_r;
  endproperty
  a_decode: assert property (p_decode) else $error("decoded code not driven");

  property p_onehot;
    !DECODE_EN && state_r == spsel_pkg::ST_SHIFT && cur_drv_r == CS_N_O
      |-> $onehot0(~CS_N_O);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one select low");

  property p_tx_empty;
    (start_go && !TX_WR) |=> TX_EMPTY;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("empty flag not set on load");

  property p_keep;
    (s_word_end and !release_now) |=> $stable(CS_N_O) ##1 $stable(CS_N_O) || fault_det;
  endproperty
  a_keep: assert property (p_keep) else $error("held select dropped");

  property p_last;
    (s_word_end and last_r) |=> s_released;
  endproperty
  a_last: assert property (p_last) else $error("select not released after last");

  property p_fault;
    fault_det |=> MODE_FAULT && !ENABLED;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not flagged");

  property p_fault_sticky;
    (MODE_FAULT && !STATUS_RD) |=> MODE_FAULT;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault flag lost");

  property p_fault_dis;
    $rose(MODE_FAULT) |-> !$past(MODE_FAULT_FLAG_DIS);
  endproperty
  a_fault_dis: assert property (p_fault_dis) else $error("fault while detection off");

  property p_disable;
    (DISABLE_CMD && state_r == spsel_pkg::ST_SHIFT && !fault_det) |=> ENABLED;
  endproperty
  a_disable: assert property (p_disable) else $error("disable cut a word");

endmodule

// ### tb/spsel_slave.sv
// Purpose: spi slave stand-in for the chip-select manager bench
// Assumes: mode 0, one slave answers on whichever line is low
// Notes:   answers the inverse of each captured bit, so replies are predictable
module spsel_slave (
  // clock
  input  wire logic        mclk,
  // bus
  input  wire logic [3:0]  cs_n,
  input  wire logic        sck,
  input  wire logic        mosi,
  output logic             miso,
  output logic [15:0]      got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sck_q;
  initial begin
    miso  = 1'b0;
    sck_q = 1'b0;
    got   = 16'h0000;
  end
  always @(posedge mclk) begin
    sck_q <= sck;
    if (cs_n != 4'hf && sck && !sck_q) begin
      got  <= {got[14:0], mosi};
      miso <= ~mosi;
    end else if (cs_n == 4'hf) begin
      // unselected: line keeps moving so a stale bit cannot pass as data
      miso <= ~miso;
    end
  end
endmodule

// ### tb/spsel_top_tb_top.sv
// Purpose: self-checking bench for the chip-select manager
// Assumes: sck half period of four master clocks, pull-ups on select lines
// Notes:   widths 8, 15, 16, 16 on configs 0..3 cover both ends of the range
module spsel_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [3:0] cs; logic [15:0] dat; int w;} spsel_note_t;
  logic                          mclk = 1'b0, rst, en_cmd, dis_cmd, last_cmd, sel_mode;
  logic                          dec_en, mode_fault_flag_dis, tx_wr, st_rd, rx_rd = 1'b0, ext_low, cs0;
  logic                          tx_empty, rx_full, tx_done, mode_fault_flag, enabled;
  logic                          sck, sck_oe, mosi, mosi_oe, miso;
  logic                          sck_q = 1'b0, rxf_q = 1'b0;
  logic [3:0]                    mr_cs, cs_n, cs_oe, cs_pin, cs_prev, cs_seen;
  logic [7:0]                    dly;
  logic [15:0]                   rx_data, got, msk;
  logic [15:0]                   lfsr_r = 16'h0060;
  spsel_pkg::spsel_cscfg_t [3:0] cfg;
  spsel_pkg::spsel_txw_t         txw;
  spsel_note_t                   q[$];
  spsel_note_t                   nt;
  int                            failures = 0, n_checks = 0, n_rel = 0, nbits = 0, r0;
  logic [3:0]                    ftab[5] = '{4'h6, 4'hd, 4'hb, 4'h7, 4'h0};

  assign cs_pin = cs_n | ~cs_oe;
  assign cs0 = ext_low ? 1'b0 : cs_pin[0];

  spsel_top DUT (.MCLK(mclk), .RST(rst), .ENABLE_CMD(en_cmd), .DISABLE_CMD(dis_cmd),
    .LAST_XFER_CMD(last_cmd), .SELECT_MODE(sel_mode), .DECODE_EN(dec_en),
    .MODE_FAULT_FLAG_DIS(mode_fault_flag_dis), .MR_CS_FIELD(mr_cs), .INTER_SEL_DLY(dly), .CS_CFG(cfg),
    .TX_WR(tx_wr), .TX_WORD(txw), .STATUS_RD(st_rd), .RX_RD(rx_rd), .TX_EMPTY(tx_empty),
    .RX_FULL(rx_full), .TX_DONE(tx_done), .MODE_FAULT(mode_fault_flag), .ENABLED(enabled),
    .RX_DATA(rx_data), .CS_N_O(cs_n), .CS_N_OE(cs_oe), .CS0_I(cs0), .SCK_O(sck),
    .SCK_OE(sck_oe), .MOSI_O(mosi), .MOSI_OE(mosi_oe), .MISO_I(miso));
  spsel_slave slv (.mclk(mclk), .cs_n(cs_pin), .sck(sck), .mosi(mosi), .miso(miso),
    .got(got));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic int wid(logic [1:0] i);
    return (cfg[i].bits >= 4'h8) ? 16 : 8 + int'(cfg[i].bits);
  endfunction
  function automatic logic [1:0] lz(logic [3:0] f);
    return !f[0] ? 2'd0 : !f[1] ? 2'd1 : !f[2] ? 2'd2 : 2'd3;
  endfunction
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(logic [31:0] got_v, logic [31:0] exp_v);
    n_checks++;
    if (got_v !== exp_v) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask
  // waits for room, then writes one word and notes what must come back
  task automatic put(logic [3:0] csf, logic [3:0] pat, int w, logic lst);
    int k;
    k = 0;
    while (tx_empty !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 3000) failures++;
    lfsr_r = lfsr_next(lfsr_r);
    txw = '{spare_hi: 7'h00, last: lst, spare: 4'h0, cs: csf, data: lfsr_r};
    // fixed mode moves 8, 15 or 16 bits, unused upper bits zero
    if (!sel_mode) txw.data = lfsr_r & (16'hffff >> (16 - w));
    tx_wr = 1'b1;
    q.push_back('{pat, lfsr_r, w});
    @(negedge mclk);
    tx_wr = 1'b0;
  endtask
  task automatic idle();
    int k;
    k = 0;
    while ((q.size() != 0 || tx_done !== 1'b1) && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 3000) failures++;
    chk(q.size(), 0);
    repeat (4) @(negedge mclk);
  endtask
  task automatic stop_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // result watcher: one note per received word
  always @(posedge mclk) begin
    sck_q <= sck;
    rxf_q <= rx_full;
    cs_prev <= cs_pin;
    if (cs_prev != 4'hf && cs_pin == 4'hf) n_rel++;
    if (sck && !sck_q) begin
      if (nbits == 0) cs_seen <= cs_pin;
      nbits++;
    end
    if (rx_full && !rxf_q) begin
      if (q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        nt = q.pop_front();
        msk = 16'hffff >> (16 - nt.w);
        chk(cs_seen, nt.cs);
        chk(nbits, nt.w);
        chk(got & msk, nt.dat & msk);
        chk(rx_data, ~nt.dat & msk);
      end
      nbits = 0;
    end
  end
  always @(negedge mclk) rx_rd <= rx_full;

  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    stop_test();
  end

  initial begin
    {rst, en_cmd, dis_cmd, last_cmd, sel_mode, dec_en, mode_fault_flag_dis} = 7'h40;
    {tx_wr, st_rd, ext_low} = '0;
    mr_cs = 4'he;
    dly = 8'h02;
    cfg = {6'h0f, 6'h08, 6'h07, 6'h00};
    txw = '0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    chk({cs_n, cs_oe, tx_empty, tx_done, enabled}, {4'hf, 4'h0, 3'b110});
    pulse(en_cmd);
    chk({enabled, sck_oe, mosi_oe}, 3'b111);
    foreach (ftab[i]) begin
      mr_cs = ftab[i];
      // word field points elsewhere and must be ignored
      put(~ftab[i], ~(4'h1 << lz(ftab[i])), wid(lz(ftab[i])), 1'b0);
      idle();
    end
    sel_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      r0 = (lfsr_r[3:0] == 4'hf) ? 4'he : lfsr_r[3:0];
      put(r0[3:0], ~(4'h1 << lz(r0[3:0])), wid(lz(r0[3:0])), 1'b0);
    end
    idle();
    dec_en = 1'b1;
    for (int c = 0; c < 15; c++) put(c[3:0], c[3:0], wid(c[3:2]), 1'b0);
    idle();
    dec_en = 1'b0;
    for (int f = 0; f < 2; f++) begin
      cfg[0].force_rel = f[0];
      r0 = n_rel;
      repeat (3) put(4'he, 4'he, 8, 1'b0);
      idle();
      chk(n_rel - r0, f ? 3 : 1);
    end
    mode_fault_flag_dis = 1'b1;
    cfg[0].keep = 1'b1;
    r0 = n_rel;
    put(4'he, 4'he, 8, 1'b0);
    idle();
    chk(cs_pin, 4'he);
    put(4'hd, 4'hd, 15, 1'b1);
    idle();
    chk(n_rel - r0, 2);
    put(4'he, 4'he, 8, 1'b0);
    idle();
    pulse(last_cmd);
    put(4'he, 4'he, 8, 1'b0);
    idle();
    chk(cs_pin, 4'hf);
    cfg[0] = 6'h00;
    mode_fault_flag_dis = 1'b0;
    put(4'hb, 4'hb, 16, 1'b0);
    @(negedge mclk);
    chk(tx_empty, 1'b1);
    repeat (20) @(negedge mclk);
    pulse(dis_cmd);
    idle();
    chk({enabled, cs_oe, cs_pin}, {1'b0, 4'h0, 4'hf});
    pulse(en_cmd);
    put(4'hb, 4'hb, 16, 1'b0);
    idle();
    ext_low = 1'b1;
    repeat (6) @(negedge mclk);
    chk({mode_fault_flag, enabled}, 2'b10);
    ext_low = 1'b0;
    pulse(st_rd);
    chk(mode_fault_flag, 1'b0);
    pulse(en_cmd);
    mode_fault_flag_dis = 1'b1;
    ext_low = 1'b1;
    repeat (6) @(negedge mclk);
    chk({mode_fault_flag, enabled}, 2'b01);
    stop_test();
  end
endmodule
